/* src/lane_codec_pkg.sv */
`default_nettype none
// ==========================================================
// Shared constants for the byte lane codec
package lane_codec_pkg;
    // ==========================================================
    // Command codes on CMD_CODE
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_MASKED_WRITE = 3'h2;
    localparam logic [2:0] CMD_READ = 3'h3;
    localparam logic [2:0] CMD_MODE_READ = 3'h4;
    localparam logic [2:0] CMD_MODE_SET = 3'h5;
    localparam logic [2:0] CMD_LP_EXIT = 3'h6;

    // ==========================================================
    // Feature mode register field positions
    localparam int FEAT_MASK_BIT = 3;
    localparam int FEAT_RD_INV_BIT = 6;
    localparam int FEAT_WR_INV_BIT = 7;

    // ==========================================================
    // Coding constants
    localparam logic [7:0] PRECOND_VALUE = 8'h00;
    localparam logic [7:0] MASK_PATTERN = 8'h0f;
    localparam logic [3:0] INV_THRESHOLD = 4'h4;
    localparam logic [1:0] PRECOND_UI = 2'h2;
    localparam int BURST_BEATS = 8;

    // ==========================================================
    // Lane sequencing
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRE = 2'b01,
        ST_READ = 2'b11,
        ST_WRITE = 2'b10
    } lane_state_t;

    typedef enum logic [1:0] {
        LAST_NONE = 2'b00,
        LAST_WRITE = 2'b01,
        LAST_MASKED = 2'b11,
        LAST_READ = 2'b10
    } last_cmd_t;
endpackage
`default_nettype wire

/* src/pin_sync.sv */
`default_nettype none
// ==========================================================
// Two flip-flop synchroniser for pin inputs
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

/* src/beat_store.sv */
`default_nettype none
// ==========================================================
// Read burst beat memory with registered read data
module beat_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] rdata_r;
    logic [WIDTH-1:0] rdata_nxt;

    always_comb begin
        rdata_nxt = mem_r[raddr];
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;
endmodule
`default_nettype wire

/* src/byte_lane_codec.sv */
`default_nettype none
// Function
// RQ1: Mode register read data uses read inversion coding like a Read.
// RQ2: Masking and write inversion off: pin ignored, input receiver off.
// RQ3: Read inversion off: pin output driver stays off during reads.
// RQ4: Masked Write with masking off is illegal and flagged.
// RQ5: Write with write inversion: invert beat when pin high.
// RQ6: Read: invert beat, pin high, when over four lines would change.
// RQ7: Tie of four after an inverted beat inverts; otherwise uninverted.
// RQ8: Masking on, write inversion off: ordinary Write ignores the pin.
// RQ9: Controller uses Masked Write for any masked beat.
// RQ10: Masked Write without inversion: skip beats with pin high.
// RQ11: Masked Write with inversion: mask on pin high and 0x0f toggle.
// RQ12: Otherwise Masked Write beats invert on pin high.
// RQ13: Inversion state holds last bus byte, starts all low.
// RQ14: Controller encodes write data with the same coding.
// RQ15: One two-way mask/invert pin per byte, sampled with data.
// RQ16: Enables come from feature register bits 3, 7 and 6.
// RQ17: Inversion state cleared on reset, mode set, listed sequences.
// RQ18: First or gapped read preconditions the bus for 2 UI.
module byte_lane_codec #(
    parameter int BURST_BEATS = lane_codec_pkg::BURST_BEATS,
    parameter int AW = $clog2(BURST_BEATS)
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Commands
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_CODE,
    input wire logic CMD_GAP,
    input wire logic [7:0] MODE_OP,
    // Read burst data load
    input wire logic RDBUF_WE,
    input wire logic [AW-1:0] RDBUF_ADDR,
    input wire logic [7:0] RDBUF_DATA,
    // Link pins
    input wire logic LINK_CK,
    input wire logic [7:0] DQ_IN,
    input wire logic MASKINV_IN,
    output logic [7:0] DQ_OUT,
    output logic DQ_OE_N,
    output logic MASKINV_OUT,
    output logic MASKINV_OE_N,
    output logic MASKINV_RX_EN,
    // Write data to the array
    output logic WR_STORE,
    output logic [7:0] WR_DATA,
    output logic [AW-1:0] WR_BEAT,
    // Status
    output logic BUSY,
    output logic ILLEGAL_CMD,
    output logic MASK_EN,
    output logic WR_INV_EN,
    output logic RD_INV_EN
);
    localparam logic [AW:0] BEAT_END = (AW+1)'(BURST_BEATS);
    localparam logic [AW:0] BEAT_LAST = (AW+1)'(BURST_BEATS - 1);

    // ==========================================================
    // Helpers
    function automatic logic [3:0] flip_count(input logic [7:0] a,
                                              input logic [7:0] b);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, a[i] ^ b[i]};
        end
        return n;
    endfunction

    function automatic logic read_invert(input logic [3:0] n,
                                         input logic prev);
        return (n > lane_codec_pkg::INV_THRESHOLD) ||
               (n == lane_codec_pkg::INV_THRESHOLD && prev);
    endfunction

    // ==========================================================
    // Pin synchronisers and read memory
    logic [9:0] pins_s;
    logic ck_s;
    logic [7:0] dq_s;
    logic mi_s;
    logic [7:0] rd_q;
    logic [AW:0] beat_r;

    pin_sync #(.WIDTH(10)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .d({LINK_CK, MASKINV_IN, DQ_IN}), // see RQ15
        .q(pins_s)
    );

    always_comb begin
        ck_s = pins_s[9];
        mi_s = pins_s[8];
        dq_s = pins_s[7:0];
    end

    beat_store #(.WIDTH(8), .DEPTH(BURST_BEATS), .AW(AW)) u_store (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .we(RDBUF_WE),
        .waddr(RDBUF_ADDR),
        .wdata(RDBUF_DATA),
        .raddr(beat_r[AW-1:0]),
        .rdata(rd_q)
    );

    // ==========================================================
    // State
    lane_codec_pkg::lane_state_t state_r, state_nxt;
    lane_codec_pkg::last_cmd_t last_r, last_nxt;
    logic [AW:0] beat_nxt;
    logic [1:0] pre_r, pre_nxt;
    logic ck_d_r, ck_d_nxt, masked_r, masked_nxt;
    logic [7:0] bus_r, bus_nxt;
    logic inv_prev_r, inv_prev_nxt;
    logic mask_en_r, mask_en_nxt, wr_inv_r, wr_inv_nxt;
    logic rd_inv_r, rd_inv_nxt;
    logic [7:0] dq_out_r, dq_out_nxt, wr_data_r, wr_data_nxt;
    logic dq_oe_n_r, dq_oe_n_nxt, mi_out_r, mi_out_nxt;
    logic mi_oe_n_r, mi_oe_n_nxt, rx_en_r, rx_en_nxt;
    logic wr_store_r, wr_store_nxt, busy_r, busy_nxt;
    logic illegal_r, illegal_nxt;
    logic [AW-1:0] wr_beat_r, wr_beat_nxt;
    logic link_edge, cmd_take, inv_now;
    logic [3:0] flips;

    always_comb begin
        link_edge = ck_s ^ ck_d_r;
        cmd_take = CMD_VALID && (state_r == lane_codec_pkg::ST_IDLE);
        flips = flip_count(rd_q, bus_r);
        inv_now = read_invert(flips, inv_prev_r); // see RQ6 see RQ7
    end

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        last_nxt = last_r;
        beat_nxt = beat_r;
        pre_nxt = pre_r;
        ck_d_nxt = ck_s;
        masked_nxt = masked_r;
        bus_nxt = bus_r;
        inv_prev_nxt = inv_prev_r;
        mask_en_nxt = mask_en_r;
        wr_inv_nxt = wr_inv_r;
        rd_inv_nxt = rd_inv_r;
        dq_out_nxt = dq_out_r;
        dq_oe_n_nxt = dq_oe_n_r;
        mi_out_nxt = mi_out_r;
        mi_oe_n_nxt = mi_oe_n_r;
        rx_en_nxt = rx_en_r;
        wr_data_nxt = wr_data_r;
        wr_beat_nxt = wr_beat_r;
        wr_store_nxt = 1'b0;
        illegal_nxt = 1'b0;
        case (state_r)
            lane_codec_pkg::ST_IDLE: begin
                if (CMD_VALID) begin
                    case (CMD_CODE)
                        lane_codec_pkg::CMD_WRITE: begin
                            state_nxt = lane_codec_pkg::ST_WRITE;
                            masked_nxt = 1'b0;
                            last_nxt = lane_codec_pkg::LAST_WRITE;
                            beat_nxt = '0;
                            rx_en_nxt = mask_en_r | wr_inv_r; // see RQ2
                        end
                        lane_codec_pkg::CMD_MASKED_WRITE: begin
                            if (!mask_en_r) begin
                                illegal_nxt = 1'b1; // see RQ4
                            end else begin
                                state_nxt = lane_codec_pkg::ST_WRITE;
                                masked_nxt = 1'b1;
                                last_nxt = lane_codec_pkg::LAST_MASKED;
                                beat_nxt = '0;
                                rx_en_nxt = 1'b1;
                                if (last_r == lane_codec_pkg::LAST_READ ||
                                    (CMD_GAP &&
                                     last_r != lane_codec_pkg::LAST_NONE)
                                   ) begin
                                    bus_nxt = lane_codec_pkg::PRECOND_VALUE;
                                    inv_prev_nxt = 1'b0; // see RQ17
                                end
                            end
                        end
                        lane_codec_pkg::CMD_READ,
                        lane_codec_pkg::CMD_MODE_READ: begin // see RQ1
                            last_nxt = lane_codec_pkg::LAST_READ;
                            beat_nxt = '0;
                            dq_oe_n_nxt = 1'b0;
                            mi_oe_n_nxt = !rd_inv_r; // see RQ3
                            if (rd_inv_r && (CMD_GAP ||
                                last_r != lane_codec_pkg::LAST_READ)) begin
                                state_nxt = lane_codec_pkg::ST_PRE;
                                pre_nxt = 2'h0;
                                bus_nxt = lane_codec_pkg::PRECOND_VALUE;
                                inv_prev_nxt = 1'b0;
                                dq_out_nxt = lane_codec_pkg::PRECOND_VALUE;
                                mi_out_nxt = 1'b0; // see RQ18
                            end else begin
                                state_nxt = lane_codec_pkg::ST_READ;
                            end
                        end
                        lane_codec_pkg::CMD_MODE_SET: begin
                            mask_en_nxt =
                                MODE_OP[lane_codec_pkg::FEAT_MASK_BIT];
                            wr_inv_nxt =
                                MODE_OP[lane_codec_pkg::FEAT_WR_INV_BIT];
                            rd_inv_nxt =
                                MODE_OP[lane_codec_pkg::FEAT_RD_INV_BIT];
                            bus_nxt = lane_codec_pkg::PRECOND_VALUE;
                            inv_prev_nxt = 1'b0; // see RQ16 see RQ17
                        end
                        lane_codec_pkg::CMD_LP_EXIT: begin
                            bus_nxt = lane_codec_pkg::PRECOND_VALUE;
                            inv_prev_nxt = 1'b0; // see RQ17
                        end
                        default: begin
                        end
                    endcase
                end
            end
            lane_codec_pkg::ST_PRE: begin
                if (link_edge) begin
                    pre_nxt = pre_r + 2'h1;
                    if (pre_r == lane_codec_pkg::PRECOND_UI - 2'h1) begin
                        state_nxt = lane_codec_pkg::ST_READ; // see RQ18
                    end
                end
            end
            lane_codec_pkg::ST_READ: begin
                if (link_edge) begin
                    if (beat_r == BEAT_END) begin
                        state_nxt = lane_codec_pkg::ST_IDLE;
                        dq_oe_n_nxt = 1'b1;
                        mi_oe_n_nxt = 1'b1;
                    end else begin
                        beat_nxt = beat_r + (AW+1)'(1);
                        if (rd_inv_r) begin
                            dq_out_nxt = inv_now ? ~rd_q : rd_q;
                            mi_out_nxt = inv_now; // see RQ6 see RQ7
                            bus_nxt = inv_now ? ~rd_q : rd_q; // see RQ13
                            inv_prev_nxt = inv_now;
                        end else begin
                            dq_out_nxt = rd_q;
                            mi_out_nxt = 1'b0;
                        end
                    end
                end
            end
            lane_codec_pkg::ST_WRITE: begin
                if (link_edge) begin
                    wr_beat_nxt = beat_r[AW-1:0];
                    beat_nxt = beat_r + (AW+1)'(1);
                    wr_store_nxt = 1'b1;
                    wr_data_nxt = dq_s;
                    bus_nxt = dq_s; // see RQ13
                    if (!masked_r) begin
                        if (wr_inv_r && mi_s) begin
                            wr_data_nxt = ~dq_s; // see RQ5 see RQ8
                        end
                    end else if (!wr_inv_r) begin
                        wr_store_nxt = !mi_s; // see RQ10
                    end else if (mi_s && ((dq_s ^ bus_r) ==
                                 lane_codec_pkg::MASK_PATTERN)) begin
                        wr_store_nxt = 1'b0; // see RQ11
                    end else if (mi_s) begin
                        wr_data_nxt = ~dq_s; // see RQ12
                    end
                    if (beat_r == BEAT_LAST) begin
                        state_nxt = lane_codec_pkg::ST_IDLE;
                        rx_en_nxt = 1'b0;
                    end
                end
            end
            default: begin
                state_nxt = lane_codec_pkg::ST_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != lane_codec_pkg::ST_IDLE);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= lane_codec_pkg::ST_IDLE;
            last_r <= lane_codec_pkg::LAST_NONE;
            beat_r <= '0;
            pre_r <= 2'h0;
            ck_d_r <= 1'b0;
            masked_r <= 1'b0;
            bus_r <= lane_codec_pkg::PRECOND_VALUE;
            inv_prev_r <= 1'b0;
            mask_en_r <= 1'b0;
            wr_inv_r <= 1'b0;
            rd_inv_r <= 1'b0;
            dq_out_r <= 8'h00;
            dq_oe_n_r <= 1'b1;
            mi_out_r <= 1'b0;
            mi_oe_n_r <= 1'b1;
            rx_en_r <= 1'b0;
            wr_data_r <= 8'h00;
            wr_beat_r <= '0;
            wr_store_r <= 1'b0;
            busy_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            last_r <= last_nxt;
            beat_r <= beat_nxt;
            pre_r <= pre_nxt;
            ck_d_r <= ck_d_nxt;
            masked_r <= masked_nxt;
            bus_r <= bus_nxt;
            inv_prev_r <= inv_prev_nxt;
            mask_en_r <= mask_en_nxt;
            wr_inv_r <= wr_inv_nxt;
            rd_inv_r <= rd_inv_nxt;
            dq_out_r <= dq_out_nxt;
            dq_oe_n_r <= dq_oe_n_nxt;
            mi_out_r <= mi_out_nxt;
            mi_oe_n_r <= mi_oe_n_nxt;
            rx_en_r <= rx_en_nxt;
            wr_data_r <= wr_data_nxt;
            wr_beat_r <= wr_beat_nxt;
            wr_store_r <= wr_store_nxt;
            busy_r <= busy_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    assign DQ_OUT = dq_out_r;
    assign DQ_OE_N = dq_oe_n_r;
    assign MASKINV_OUT = mi_out_r;
    assign MASKINV_OE_N = mi_oe_n_r;
    assign MASKINV_RX_EN = rx_en_r;
    assign WR_STORE = wr_store_r;
    assign WR_DATA = wr_data_r;
    assign WR_BEAT = wr_beat_r;
    assign BUSY = busy_r;
    assign ILLEGAL_CMD = illegal_r;
    assign MASK_EN = mask_en_r;
    assign WR_INV_EN = wr_inv_r;
    assign RD_INV_EN = rd_inv_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    logic wr_edge, rd_edge;
    always_comb begin
        wr_edge = link_edge && state_r == lane_codec_pkg::ST_WRITE;
        rd_edge = link_edge && state_r == lane_codec_pkg::ST_READ &&
                  beat_r != BEAT_END;
    end

    mode_capture_a: assert property ( // see RQ16
        cmd_take && CMD_CODE == lane_codec_pkg::CMD_MODE_SET |=>
        MASK_EN == $past(MODE_OP[3]) && WR_INV_EN == $past(MODE_OP[7]) &&
        RD_INV_EN == $past(MODE_OP[6]) && bus_r == 8'h00)
        else $error("mode set not applied");
    rx_off_a: assert property ( // see RQ2
        !mask_en_r && !wr_inv_r |-> !MASKINV_RX_EN)
        else $error("receiver on with masking and inversion off");
    read_drv_off_a: assert property ( // see RQ3
        !rd_inv_r |-> MASKINV_OE_N)
        else $error("pin driver on with read inversion off");
    illegal_mw_a: assert property ( // see RQ4
        cmd_take && CMD_CODE == lane_codec_pkg::CMD_MASKED_WRITE &&
        !mask_en_r |=> ILLEGAL_CMD && !BUSY)
        else $error("illegal masked write not refused");
    wr_invert_a: assert property ( // see RQ5
        wr_edge && !masked_r && wr_inv_r |=>
        WR_STORE && WR_DATA == ($past(mi_s) ? ~$past(dq_s) : $past(dq_s)))
        else $error("write inversion wrong");
    plain_write_a: assert property ( // see RQ8
        wr_edge && !masked_r && !wr_inv_r |=>
        WR_STORE && WR_DATA == $past(dq_s))
        else $error("plain write modified or masked");
    mask_skip_a: assert property ( // see RQ10
        wr_edge && masked_r && !wr_inv_r |=> WR_STORE == !$past(mi_s))
        else $error("masked beat handling wrong");
    mask_pattern_a: assert property ( // see RQ11
        wr_edge && masked_r && wr_inv_r && mi_s &&
        (dq_s ^ bus_r) == 8'h0f |=> !WR_STORE)
        else $error("mask pattern not masked");
    mask_invert_a: assert property ( // see RQ12
        wr_edge && masked_r && wr_inv_r && (dq_s ^ bus_r) != 8'h0f |=>
        WR_STORE && WR_DATA == ($past(mi_s) ? ~$past(dq_s) : $past(dq_s)))
        else $error("masked write inversion wrong");
    read_over_a: assert property ( // see RQ6
        rd_edge && rd_inv_r && flips > 4'h4 |=>
        MASKINV_OUT && DQ_OUT == ~$past(rd_q) && bus_r == DQ_OUT)
        else $error("read beat over threshold not inverted");
    read_tie_a: assert property ( // see RQ7
        rd_edge && rd_inv_r && flips <= 4'h4 |=>
        MASKINV_OUT == ($past(flips) == 4'h4 && $past(inv_prev_r)))
        else $error("read tie coding wrong");
    precond_a: assert property ( // see RQ18
        cmd_take && rd_inv_r && CMD_GAP &&
        (CMD_CODE == lane_codec_pkg::CMD_READ ||
         CMD_CODE == lane_codec_pkg::CMD_MODE_READ) |=>
        state_r == lane_codec_pkg::ST_PRE && DQ_OUT == 8'h00 &&
        !MASKINV_OUT && !MASKINV_OE_N && !DQ_OE_N)
        else $error("read preconditioning missing");

    cover_masked_skip: cover property (wr_edge && masked_r && mi_s);
    cover_read_invert: cover property (rd_edge && rd_inv_r && inv_now);
    cover_mode_read: cover property (
        cmd_take && CMD_CODE == lane_codec_pkg::CMD_MODE_READ && rd_inv_r);
    cover_illegal: cover property (ILLEGAL_CMD);
endmodule
`default_nettype wire

/* tb/ctrl_model.sv */
`default_nettype none
// ==========
// Controller side of one byte lane
module ctrl_model (
    // Frame request
    input wire logic go,
    input wire logic inv_on,
    input wire logic [63:0] beats,
    input wire logic [7:0] masks,
    // Link pins
    output logic link_ck,
    output logic [7:0] dq,
    output logic mi,
    output logic fin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] st, d;
    int n;
    initial {link_ck, dq, mi, fin} = {1'b0, 8'h00, 1'b0, 1'b1};
    always @(posedge go) begin
        fin = 1'b0;
        {st, mi} = 9'h000;
        #25;
        for (int k = 0; k < 12; k++) begin
            d = beats[8*(k%8) +: 8];
            n = $countones(st ^ d);
            if (k < 8 && masks[k]) begin
                dq = inv_on ? st ^ 8'h0f : ~st;
                mi = 1'b1;
            end else if (inv_on) begin
                mi = (n > 4 || (n == 4 && mi)) && (st ^ ~d) != 8'h0f;
                dq = mi ? ~d : d;
            end else begin
                dq = d;
                mi = (masks == 8'h00) && ^d;
            end
            st = dq;
            #100 link_ck = ~link_ck;
            #100;
        end
        dq = ~dq;
        fin = 1'b1;
    end
endmodule
`default_nettype wire

/* tb/byte_lane_codec_tb.sv */
`default_nettype none
// ==========
// Bench for one byte lane
module byte_lane_codec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rstn = 1'b0, cv = 1'b0, gap = 1'b0, rwe = 1'b0;
    logic go = 1'b0, inv = 1'b0, rdon = 1'b0;
    logic [2:0] code = 3'h0, ra = 3'h0, wb;
    logic [7:0] op = 8'h00, rdat = 8'h00, masks = 8'h00, dq, dqo, wd;
    logic lck, mi, fin, dqoe, mio, mioe, rx, ws, busy, ill, men, wen, ren;
    logic [63:0] beats = 64'h0;
    logic [31:0] seed = 32'h9;
    logic [10:0] wq[$];
    logic [8:0] rq[$];
    logic [7:0] modes[6] = '{8'h00, 8'h80, 8'h08, 8'h88, 8'hc8, 8'h40};
    int n_fail = 0, total_checks = 0, cyc = 0, ec = 0, rd_end = 9;
    logic [7:0] rd_st = 8'h00;
    logic rd_pv = 1'b0;
    always #25 clk = ~clk;
    byte_lane_codec dut (.CLK_SYS(clk), .RSTN(rstn), .CMD_VALID(cv),
        .CMD_CODE(code), .CMD_GAP(gap), .MODE_OP(op), .RDBUF_WE(rwe),
        .RDBUF_ADDR(ra), .RDBUF_DATA(rdat), .LINK_CK(lck), .DQ_IN(dq),
        .MASKINV_IN(mi), .DQ_OUT(dqo), .DQ_OE_N(dqoe), .MASKINV_OUT(mio),
        .MASKINV_OE_N(mioe), .MASKINV_RX_EN(rx), .WR_STORE(ws),
        .WR_DATA(wd), .WR_BEAT(wb), .BUSY(busy), .ILLEGAL_CMD(ill),
        .MASK_EN(men), .WR_INV_EN(wen), .RD_INV_EN(ren));
    ctrl_model partner (.go(go), .inv_on(inv), .beats(beats),
        .masks(masks), .link_ck(lck), .dq(dq), .mi(mi), .fin(fin));
    // ==========
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmd(logic [2:0] c, logic g);
        @(posedge clk);
        cv <= 1'b1;
        code <= c;
        gap <= g;
        @(posedge clk);
        cv <= 1'b0;
    endtask
    task automatic frame();
        ec = 0;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wait (fin === 1'b0);
        wait (fin === 1'b1);
        repeat (4) @(posedge clk);
        chk("busy", 16'h0, 16'(busy));
    endtask
    task automatic wr(logic [2:0] c, logic g);
        beats = {xs(), xs()};
        masks = g ? 8'(xs()) | 8'h01 : 8'h00;
        inv = op[7];
        for (int k = 0; k < 8; k++)
            if (!(op[3] && masks[k])) wq.push_back({3'(k), beats[8*k +: 8]});
        cmd(c, g);
        #1;
        if (g && !op[3]) begin
            chk("illegal", 16'h1, 16'(ill));
            wq.delete();
        end else begin
            chk("rx_en", 16'(op[7] | op[3]), 16'(rx));
            frame();
        end
    endtask
    task automatic rd(logic [2:0] c, logic g);
        logic [7:0] w;
        int n;
        if (g) begin
            rd_st = 8'h00;
            rd_pv = 1'b0;
        end
        rd_end = (op[6] && g) ? 11 : 9;
        for (int k = 0; k < 8; k++) begin
            w = 8'(xs());
            @(posedge clk);
            rwe <= 1'b1;
            ra <= 3'(k);
            rdat <= w;
            n = $countones(rd_st ^ w);
            rd_pv = n > 4 || (n == 4 && rd_pv);
            rd_st = rd_pv ? ~w : w;
            rq.push_back({rd_pv, rd_st});
        end
        @(posedge clk);
        rwe <= 1'b0;
        rdon = 1'b1;
        cmd(c, g);
        frame();
        rdon = 1'b0;
        rq.delete();
    endtask
    // ==========
    // Result watchers
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            n_fail++;
            report_and_stop();
        end
        if (ws === 1'b1) begin
            if (wq.size() == 0)
                chk("masked", 16'h0, 16'h1);
            else
                chk("store", 16'(wq.pop_front()), 16'({wb, wd}));
        end
    end
    always @(lck) if (rdon) begin
        ec++;
        chk("dq_oe_n", 16'(ec > rd_end), 16'(dqoe));
        chk("dmi_oe_n", 16'(!op[6] || ec > rd_end), 16'(mioe));
        if (op[6] && ec >= rd_end - 7 && ec <= rd_end)
            chk("read", 16'(rq.pop_front()), 16'({mio, dqo}));
    end
    // ==========
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        foreach (modes[i]) begin
            op <= modes[i];
            cmd(lane_codec_pkg::CMD_MODE_SET, 1'b0);
            #1 chk("en", 16'({op[3], op[7], op[6]}), 16'({men, wen, ren}));
            wr(lane_codec_pkg::CMD_WRITE, 1'b0);
            wr(lane_codec_pkg::CMD_MASKED_WRITE, 1'b1);
            rd(i == 4 ? lane_codec_pkg::CMD_MODE_READ
                      : lane_codec_pkg::CMD_READ, 1'b1);
            if (i % 2 == 1) begin
                cmd(lane_codec_pkg::CMD_LP_EXIT, 1'b0);
                rd_st = 8'h00;
                rd_pv = 1'b0;
            end
            rd(lane_codec_pkg::CMD_READ, 1'b0);
        end
        chk("pending", 16'h0, 16'(wq.size()));
        report_and_stop();
    end
endmodule
`default_nettype wire
